// >>> pcfw_consts.vh
// Constants for the program counter, return stack and fetch block
// What this block does
// - Enabled interrupt wake pushes counter onto stack
// - Enabled interrupt wake loads vector 0008h/0018h
// - Wake sets at least one cause flag bit
// - Program fetch bus separate from data bus
// - Counter is 21 bits, byte addresses 2 Mbytes
// - Fetch above implemented memory returns zeros
// - Implemented memory 64 or 128 Kbytes
// - Every reset returns counter to 0000h
// - Counter bit zero held low, steps by two
// - Push increments pointer, then writes counter
// - Stack holds 31 entries, 5-bit pointer
`ifndef PCFW_CONSTS_VH
`define PCFW_CONSTS_VH

// Counter and stack geometry
`define PCFW_PC_W 21
`define PCFW_SP_W 5
`define PCFW_STACK_DEPTH 31
`define PCFW_INSTR_W 16
`define PCFW_FLAG_W 8

// Vectors and step
`define PCFW_RESET_VEC 21'h000000
`define PCFW_HI_VEC 21'h000008
`define PCFW_LO_VEC 21'h000018
`define PCFW_PC_STEP 21'h000002

// Implemented memory sizes in instruction words
`define PCFW_SMALL_WORDS 32768
`define PCFW_LARGE_WORDS 65536

// Register byte addresses
`define PCFW_ADDR_W 8
`define PCFW_REG_CTRL 8'h00
`define PCFW_REG_PC 8'h04
`define PCFW_REG_SP 8'h08
`define PCFW_REG_TOS 8'h0c
`define PCFW_REG_INTC 8'h10
`define PCFW_REG_PIRF 8'h14
`define PCFW_REG_STAT 8'h18

// Control field positions and reset values
`define PCFW_CTRL_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE 0
`define PCFW_CTRL_LOW_PRIORITY_GLOBAL_IRQ_ENABLE 1
`define PCFW_CTRL_LARGE 2
`define PCFW_CTRL_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_RST 1'b0
`define PCFW_CTRL_LOW_PRIORITY_GLOBAL_IRQ_ENABLE_RST 1'b0

// Status field positions
`define PCFW_STAT_FULL 0
`define PCFW_STAT_OVF 1

// Flag raised when a wake carries no cause
`define PCFW_INTC_UNK_BIT 7

`endif

// >>> pcfw_stack_ram.v
// Return address stack storage with registered read
`timescale 1ns/100ps
`default_nettype none
`include "pcfw_consts.vh"

module pcfw_stack_ram #(
  parameter DEPTH = `PCFW_STACK_DEPTH,
  parameter AW = `PCFW_SP_W,
  parameter DW = `PCFW_PC_W
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_ptr,
  input wire [DW-1:0] wr_data,
  // Read port
  input wire [AW-1:0] rd_ptr,
  output reg [DW-1:0] rd_data_q
);

  // Entry zero has no storage
  reg [DW-1:0] mem [1:DEPTH];

  always @(posedge pclk) begin
    if (wr_en && (wr_ptr != {AW{1'b0}})) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= {DW{1'b0}};
    end else if (rd_ptr == {AW{1'b0}}) begin
      rd_data_q <= {DW{1'b0}};
    end else begin
      rd_data_q <= mem[rd_ptr];
    end
  end

endmodule // pcfw_stack_ram
`default_nettype wire

// >>> pcfw_fetch.v
// Instruction fetch on the program memory bus
`timescale 1ns/100ps
`default_nettype none
`include "pcfw_consts.vh"

module pcfw_fetch #(
  parameter SMALL_WORDS = `PCFW_SMALL_WORDS,
  parameter LARGE_WORDS = `PCFW_LARGE_WORDS
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Counter and size select
  input wire [`PCFW_PC_W-1:0] pc,
  input wire mem_large,
  // Program memory bus
  output reg [`PCFW_PC_W-1:0] prog_addr_q,
  output reg prog_rd_q,
  input wire [`PCFW_INSTR_W-1:0] prog_rdata,
  // Fetched instruction
  output reg [`PCFW_INSTR_W-1:0] instr_q,
  output reg instr_valid_q
);

  localparam integer SMALL_BYTES = SMALL_WORDS * 2;
  localparam integer LARGE_BYTES = LARGE_WORDS * 2;

  wire [31:0] pc_ext;
  wire in_range_d;
  reg addr_valid_q;

  assign pc_ext = {11'h000, pc};
  // Size bound by family member
  assign in_range_d = mem_large ? (pc_ext < LARGE_BYTES) :
                                  (pc_ext < SMALL_BYTES);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_addr_q <= `PCFW_RESET_VEC;
      prog_rd_q <= 1'b0;
      addr_valid_q <= 1'b0;
      instr_q <= {`PCFW_INSTR_W{1'b0}};
      instr_valid_q <= 1'b0;
    end else begin
      prog_addr_q <= pc;
      prog_rd_q <= in_range_d;
      addr_valid_q <= 1'b1;
      instr_valid_q <= addr_valid_q;
      if (prog_rd_q) begin
        instr_q <= prog_rdata;
      end else begin
        instr_q <= {`PCFW_INSTR_W{1'b0}};
      end
    end
  end

endmodule // pcfw_fetch
`default_nettype wire

// >>> pcfw_top.v
// Program counter, wake vectoring and APB registers
`timescale 1ns/100ps
`default_nettype none
`include "pcfw_consts.vh"

module pcfw_top #(
  parameter SMALL_WORDS = `PCFW_SMALL_WORDS,
  parameter LARGE_WORDS = `PCFW_LARGE_WORDS,
  parameter LARGE_RST = 1'b1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PCFW_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // Core sequencing
  input wire fetch_advance,
  input wire wake_req,
  input wire wake_high_prio,
  input wire [`PCFW_FLAG_W-1:0] wake_cause_intc,
  input wire [`PCFW_FLAG_W-1:0] wake_cause_pir,
  output reg [`PCFW_PC_W-1:0] pc_q,
  output reg vector_taken_q,
  // Program memory bus
  output wire [`PCFW_PC_W-1:0] prog_addr_q,
  output wire prog_rd_q,
  input wire [`PCFW_INSTR_W-1:0] prog_rdata,
  output wire [`PCFW_INSTR_W-1:0] instr_q,
  output wire instr_valid_q
);

  // Control and status state
  reg high_priority_global_irq_enable_q;
  reg low_priority_global_irq_enable_q;
  reg mem_large_q;
  reg [`PCFW_SP_W-1:0] sp_q;
  reg stk_full_q;
  reg stk_ovf_q;
  reg [`PCFW_FLAG_W-1:0] intc_q;
  reg [`PCFW_FLAG_W-1:0] pir_q;
  wire [`PCFW_PC_W-1:0] tos_rd;

  // APB decode
  wire apb_done;
  wire apb_wr;
  wire wr_ctrl;
  wire wr_pc;
  wire wr_sp;
  wire wr_tos;
  wire wr_intc;
  wire wr_pirf;
  wire wr_stat;
  reg [31:0] rdata_d;
  reg mapped_d;

  assign apb_done = psel & penable & pready_q;
  assign apb_wr = apb_done & pwrite;
  assign wr_ctrl = apb_wr & (paddr == `PCFW_REG_CTRL);
  assign wr_pc = apb_wr & (paddr == `PCFW_REG_PC);
  assign wr_sp = apb_wr & (paddr == `PCFW_REG_SP);
  assign wr_tos = apb_wr & (paddr == `PCFW_REG_TOS);
  assign wr_intc = apb_wr & (paddr == `PCFW_REG_INTC);
  assign wr_pirf = apb_wr & (paddr == `PCFW_REG_PIRF);
  assign wr_stat = apb_wr & (paddr == `PCFW_REG_STAT);

  // Wake vectoring
  wire any_gie;
  wire push;
  wire push_room;
  wire [`PCFW_SP_W-1:0] sp_inc;
  wire [`PCFW_PC_W-1:0] vec_d;
  wire [`PCFW_FLAG_W-1:0] intc_set;
  wire [`PCFW_FLAG_W-1:0] pir_set;
  wire no_cause;

  assign any_gie = high_priority_global_irq_enable_q | low_priority_global_irq_enable_q;
  assign push = wake_req & any_gie;
  assign push_room = (sp_q != `PCFW_STACK_DEPTH);
  assign sp_inc = sp_q + {{(`PCFW_SP_W-1){1'b0}}, 1'b1};
  assign vec_d = wake_high_prio ? `PCFW_HI_VEC : `PCFW_LO_VEC;
  assign no_cause = (wake_cause_intc == {`PCFW_FLAG_W{1'b0}}) &&
                    (wake_cause_pir == {`PCFW_FLAG_W{1'b0}});
  assign intc_set = wake_req ?
    (wake_cause_intc |
     ({{(`PCFW_FLAG_W-1){1'b0}}, no_cause} << `PCFW_INTC_UNK_BIT)) :
    {`PCFW_FLAG_W{1'b0}};
  assign pir_set = wake_req ? wake_cause_pir : {`PCFW_FLAG_W{1'b0}};

  // Stack write steering
  wire stk_wr;
  wire [`PCFW_SP_W-1:0] stk_wr_ptr;
  wire [`PCFW_PC_W-1:0] stk_wr_data;

  // Push writes current counter at the incremented pointer
  assign stk_wr = (push & push_room) | wr_tos;
  assign stk_wr_ptr = (push & push_room) ? sp_inc : sp_q;
  assign stk_wr_data = (push & push_room) ? pc_q :
                       {pwdata[`PCFW_PC_W-1:1], 1'b0};

  pcfw_stack_ram #(
    .DEPTH(`PCFW_STACK_DEPTH),
    .AW(`PCFW_SP_W),
    .DW(`PCFW_PC_W)
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(stk_wr),
    .wr_ptr(stk_wr_ptr),
    .wr_data(stk_wr_data),
    .rd_ptr(sp_q),
    .rd_data_q(tos_rd)
  );

  pcfw_fetch #(
    .SMALL_WORDS(SMALL_WORDS),
    .LARGE_WORDS(LARGE_WORDS)
  ) u_fetch (
    .pclk(pclk),
    .presetn(presetn),
    .pc(pc_q),
    .mem_large(mem_large_q),
    .prog_addr_q(prog_addr_q),
    .prog_rd_q(prog_rd_q),
    .prog_rdata(prog_rdata),
    .instr_q(instr_q),
    .instr_valid_q(instr_valid_q)
  );

  // Program counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= `PCFW_RESET_VEC;
      vector_taken_q <= 1'b0;
    end else begin
      vector_taken_q <= push;
      if (push) begin
        pc_q <= vec_d;
      end else if (wr_pc) begin
        pc_q <= {pwdata[`PCFW_PC_W-1:1], 1'b0};
      end else if (fetch_advance) begin
        pc_q <= pc_q + `PCFW_PC_STEP;
      end
    end
  end

  // Stack pointer and stack status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= {`PCFW_SP_W{1'b0}};
      stk_full_q <= 1'b0;
      stk_ovf_q <= 1'b0;
    end else begin
      if (push & push_room) begin
        sp_q <= sp_inc;
      end else if (wr_sp) begin
        sp_q <= pwdata[`PCFW_SP_W-1:0];
      end
      if (push & (sp_inc == `PCFW_STACK_DEPTH)) begin
        stk_full_q <= 1'b1;
      end else if (wr_stat & pwdata[`PCFW_STAT_FULL]) begin
        stk_full_q <= 1'b0;
      end
      if (push & ~push_room) begin
        stk_ovf_q <= 1'b1;
      end else if (wr_stat & pwdata[`PCFW_STAT_OVF]) begin
        stk_ovf_q <= 1'b0;
      end
    end
  end

  // Control and cause flags, set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_priority_global_irq_enable_q <= `PCFW_CTRL_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE_RST;
      low_priority_global_irq_enable_q <= `PCFW_CTRL_LOW_PRIORITY_GLOBAL_IRQ_ENABLE_RST;
      mem_large_q <= 1'b0;
      intc_q <= {`PCFW_FLAG_W{1'b0}};
      pir_q <= {`PCFW_FLAG_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        high_priority_global_irq_enable_q <= pwdata[`PCFW_CTRL_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE];
        low_priority_global_irq_enable_q <= pwdata[`PCFW_CTRL_LOW_PRIORITY_GLOBAL_IRQ_ENABLE];
        mem_large_q <= pwdata[`PCFW_CTRL_LARGE];
      end else if (!(psel | penable) && (mem_large_q != LARGE_RST) &&
                   !vector_taken_q && (sp_q == {`PCFW_SP_W{1'b0}}) &&
                   (pc_q == `PCFW_RESET_VEC) && !instr_valid_q) begin
        mem_large_q <= LARGE_RST;
      end
      intc_q <= (intc_q & ~(wr_intc ? pwdata[`PCFW_FLAG_W-1:0] :
                 {`PCFW_FLAG_W{1'b0}})) | intc_set;
      pir_q <= (pir_q & ~(wr_pirf ? pwdata[`PCFW_FLAG_W-1:0] :
                {`PCFW_FLAG_W{1'b0}})) | pir_set;
    end
  end

  // Read mux
  always @* begin
    rdata_d = 32'h00000000;
    mapped_d = 1'b1;
    if (paddr == `PCFW_REG_CTRL) begin
      rdata_d[`PCFW_CTRL_HIGH_PRIORITY_GLOBAL_IRQ_ENABLE] = high_priority_global_irq_enable_q;
      rdata_d[`PCFW_CTRL_LOW_PRIORITY_GLOBAL_IRQ_ENABLE] = low_priority_global_irq_enable_q;
      rdata_d[`PCFW_CTRL_LARGE] = mem_large_q;
    end else if (paddr == `PCFW_REG_PC) begin
      rdata_d[`PCFW_PC_W-1:0] = pc_q;
    end else if (paddr == `PCFW_REG_SP) begin
      rdata_d[`PCFW_SP_W-1:0] = sp_q;
    end else if (paddr == `PCFW_REG_TOS) begin
      rdata_d[`PCFW_PC_W-1:0] = tos_rd;
    end else if (paddr == `PCFW_REG_INTC) begin
      rdata_d[`PCFW_FLAG_W-1:0] = intc_q;
    end else if (paddr == `PCFW_REG_PIRF) begin
      rdata_d[`PCFW_FLAG_W-1:0] = pir_q;
    end else if (paddr == `PCFW_REG_STAT) begin
      rdata_d[`PCFW_STAT_FULL] = stk_full_q;
      rdata_d[`PCFW_STAT_OVF] = stk_ovf_q;
    end else begin
      mapped_d = 1'b0;
    end
  end

  // APB answer, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
        pslverr_q <= ~mapped_d;
        prdata_q <= pwrite ? 32'h00000000 : rdata_d;
      end else begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h00000000;
      end
    end
  end

endmodule // pcfw_top
`default_nettype wire

// >>> pcfw_flash_model.sv
// Behavioural program flash array on its own bus
`timescale 1ns/100ps
`default_nettype none

module pcfw_flash_model (
  // Clock
  input wire logic pclk,
  // Program memory bus
  input wire logic [20:0] prog_addr_q,
  input wire logic prog_rd_q,
  output logic [15:0] prog_rdata
);
  logic [15:0] idle_q = 16'h0;
  // Unselected bus shows a moving pattern, never stale data
  always @(posedge pclk) begin
    idle_q <= idle_q + 16'h3;
  end
  // Own fetch bus, word read in the addressed cycle
  assign prog_rdata = prog_rd_q ? ~prog_addr_q[16:1] : idle_q;
endmodule // pcfw_flash_model

`default_nettype wire

// >>> pcfw_top_asserts.sv
// Port checker for the program counter and fetch block
`timescale 1ns/100ps
`default_nettype none
`include "pcfw_consts.vh"

module pcfw_top_asserts #(
  parameter SMALL_WORDS = 32768,
  parameter LARGE_WORDS = 65536
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PCFW_ADDR_W-1:0] paddr,
  input wire pready_q,
  // Core sequencing
  input wire fetch_advance,
  input wire wake_req,
  input wire wake_high_prio,
  input wire [`PCFW_PC_W-1:0] pc_q,
  input wire vector_taken_q,
  // Program memory bus
  input wire [`PCFW_PC_W-1:0] prog_addr_q,
  input wire prog_rd_q,
  input wire [`PCFW_INSTR_W-1:0] prog_rdata,
  input wire [`PCFW_INSTR_W-1:0] instr_q
);
  logic pc_wr;
  assign pc_wr = psel && penable && pready_q && pwrite &&
    paddr == `PCFW_REG_PC;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Counter one word on
  sequence s_step;
    ##1 pc_q == $past(pc_q) + 21'h2;
  endsequence
  a_reset_pc_zero: assert property ($past(!presetn) |-> pc_q == 21'h0)
    else $error("pc not at reset vector");
  a_pc_even: assert property (!pc_q[0] && !prog_addr_q[0])
    else $error("odd counter");
  a_advance_two: assert property (
    fetch_advance && !wake_req && !pc_wr |-> s_step)
    else $error("counter step not two");
  a_vector_addr: assert property (vector_taken_q |-> pc_q ==
    ($past(wake_high_prio) ? `PCFW_HI_VEC : `PCFW_LO_VEC))
    else $error("wrong vector");
  a_vector_cause: assert property (vector_taken_q |-> $past(wake_req))
    else $error("vector without wake");
  a_fetch_follow: assert property (1 |=> prog_addr_q == $past(pc_q))
    else $error("fetch address not counter");
  a_range_top: assert property (
    prog_rd_q |-> prog_addr_q < 2 * LARGE_WORDS)
    else $error("read beyond memory");
  a_small_in: assert property (
    $past(presetn, 2) && prog_addr_q < 2 * SMALL_WORDS |-> prog_rd_q)
    else $error("no read inside memory");
  a_zero_fill: assert property (!prog_rd_q |=> instr_q == 16'h0)
    else $error("unimplemented fetch not zero");
  a_data_pass: assert property (
    prog_rd_q |=> instr_q == $past(prog_rdata))
    else $error("fetched word lost");
endmodule // pcfw_top_asserts

bind pcfw_top pcfw_top_asserts #(.SMALL_WORDS(SMALL_WORDS),
  .LARGE_WORDS(LARGE_WORDS)) i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready_q, .fetch_advance, .wake_req, .wake_high_prio,
  .pc_q, .vector_taken_q, .prog_addr_q, .prog_rd_q, .prog_rdata, .instr_q);

`default_nettype wire

// >>> pcfw_top_tb.sv
// Self-checking bench for the program counter and fetch block
`timescale 1ns/100ps
`default_nettype none
`include "pcfw_consts.vh"

module pcfw_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_q, rd;
  logic pready_q, pslverr_q, vector_taken_q, prog_rd_q, instr_valid_q, err;
  logic fetch_advance = 1'b0;
  logic wake_req = 1'b0;
  logic wake_high_prio = 1'b0;
  logic [7:0] wake_cause_intc = 8'h00;
  logic [7:0] wake_cause_pir = 8'h00;
  logic [20:0] pc_q, prog_addr_q;
  logic [15:0] prog_rdata, instr_q;
  int failures = 0;
  int comparisons = 0;

  always #25 pclk = ~pclk;

  pcfw_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata_q, .pready_q, .pslverr_q, .fetch_advance, .wake_req,
    .wake_high_prio, .wake_cause_intc, .wake_cause_pir, .pc_q,
    .vector_taken_q, .prog_addr_q, .prog_rd_q, .prog_rdata, .instr_q,
    .instr_valid_q);
  pcfw_flash_model i_mem (.pclk, .prog_addr_q, .prog_rd_q, .prog_rdata);

  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) failures++;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic wake(input logic hi, input logic [7:0] pir);
    @(posedge pclk);
    wake_req <= 1'b1;
    wake_high_prio <= hi;
    wake_cause_pir <= pir;
    @(posedge pclk);
    wake_req <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("pc", `PCFW_REG_PC, 32'h0);
    rdchk("sp", `PCFW_REG_SP, 32'h0);
    rdchk("ctrl", `PCFW_REG_CTRL, 32'h4);
    rdchk("unmapped", 8'h1c, 32'h0);
    chk("slave error", err, 32'h1);
    $display("reset test done");
    @(posedge pclk);
    fetch_advance <= 1'b1;
    repeat (3) @(posedge pclk);
    fetch_advance <= 1'b0;
    rdchk("pc step", `PCFW_REG_PC, 32'h6);
    wake(1'b1, 8'h00);
    rdchk("pc no vector", `PCFW_REG_PC, 32'h6);
    rdchk("intc flag", `PCFW_REG_INTC, 32'h80);
    apb(1'b1, `PCFW_REG_CTRL, 32'h7);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `PCFW_REG_PC, 32'h101);
      wake(k == 0, 8'h01);
      rdchk("vector", `PCFW_REG_PC, k ? 32'h18 : 32'h8);
      rdchk("push ptr", `PCFW_REG_SP, k + 1);
      rdchk("stack top", `PCFW_REG_TOS, 32'h100);
    end
    rdchk("pir flag", `PCFW_REG_PIRF, 32'h1);
    $display("wake test done");
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `PCFW_REG_CTRL, k == 2 ? 32'h4 : 32'h0);
      apb(1'b1, `PCFW_REG_PC, k == 1 ? 32'hfffe : 32'h10000);
      repeat (3) @(posedge pclk);
      chk("word", instr_q, k == 0 ? 32'h0 :
        (k == 1 ? 32'h8000 : 32'h7fff));
    end
    $display("fetch range test done");
    apb(1'b1, `PCFW_REG_CTRL, 32'h5);
    apb(1'b1, `PCFW_REG_SP, 32'h1e);
    wake(1'b1, 8'h02);
    rdchk("sp at top", `PCFW_REG_SP, 32'h1f);
    rdchk("full flag", `PCFW_REG_STAT, 32'h1);
    rdchk("top entry", `PCFW_REG_TOS, 32'h10000);
    wake(1'b1, 8'h02);
    rdchk("sp held", `PCFW_REG_SP, 32'h1f);
    rdchk("overflow flag", `PCFW_REG_STAT, 32'h3);
    rdchk("top kept", `PCFW_REG_TOS, 32'h10000);
    apb(1'b1, `PCFW_REG_STAT, 32'h3);
    rdchk("stat cleared", `PCFW_REG_STAT, 32'h0);
    apb(1'b1, `PCFW_REG_INTC, 32'h80);
    rdchk("intc cleared", `PCFW_REG_INTC, 32'h0);
    $display("stack test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pc in reset", pc_q, 32'h0);
    chk("valid in reset", instr_valid_q, 32'h0);
    presetn <= 1'b1;
    rdchk("pc after reset", `PCFW_REG_PC, 32'h0);
    rdchk("sp after reset", `PCFW_REG_SP, 32'h0);
    rdchk("ctrl after reset", `PCFW_REG_CTRL, 32'h4);
    rdchk("stat after reset", `PCFW_REG_STAT, 32'h0);
    chk("fetch valid", instr_valid_q, 32'h1);
    $display("second reset test done");
    tally_and_finish();
  end

  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule // pcfw_top_tb

`default_nettype wire
